// ---- design/prl1_pkg.sv ----
package prl1_pkg;
  // ==========================================================
  // timing
  localparam int CLK_HZ        = 25_000_000;
  localparam int PERSIST_MS    = 10;
  // least persistence time in whole cycles, 250000 at 25 MHz, not rounded up
  localparam int PERSIST_CYC   = (CLK_HZ / 1000 * PERSIST_MS + 0);
  localparam int AIS_WIN_BITS  = 512;
  localparam int AIS_MIN_ZEROS = 3;
  localparam int SYNC_STAGES   = 3;

  // ==========================================================
  // error indication codes carried with a management event
  localparam logic [2:0] EI_POWER_LOSS = 3'h0;
  localparam logic [2:0] EI_FAULT_ONE  = 3'h1;
  localparam logic [2:0] EI_FAULT_TWO  = 3'h2;
  localparam logic [2:0] EI_FAULT_THR  = 3'h3;
  localparam logic [2:0] EI_FAULT_FOUR = 3'h4;

  // ==========================================================
  // state sets, one-hot
  typedef enum logic [6:0] {
    user_power_off_state   = 7'h01,
    user_operational_state = 7'h02,
    user_fault_one_state   = 7'h04,
    user_fault_two_state   = 7'h08,
    user_fault_three_state = 7'h10,
    user_fault_four_state  = 7'h20,
    user_power_on_state    = 7'h40
  } prl1_ust_t;

  typedef enum logic [6:0] {
    network_power_off_state   = 7'h01,
    network_operational_state = 7'h02,
    network_fault_one_state   = 7'h04,
    network_fault_two_state   = 7'h08,
    network_fault_three_state = 7'h10,
    network_fault_four_state  = 7'h20,
    network_power_on_state    = 7'h40
  } prl1_nst_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic frame_aligned;
    logic sig_lost;
    logic bit_stb;
    logic bit_val;
    logic a_stb;
    logic a_val;
    logic e_stb;
    logic e_val;
    logic crc_err;
  } prl1_rx_t;

  typedef struct packed {
    logic remote_alarm;
    logic all_ones_alarm_signal;
    logic alarm_crc;
    logic lost;
  } prl1_det_t;

  typedef struct packed {
    logic send;
    logic crc_bits;
    logic remote_alarm;
    logic all_ones;
    logic cont_crc_report;
    logic timing;
  } prl1_tx_t;

  typedef struct packed {
    logic       ph_ai;
    logic       ph_di;
    logic       mph_ai;
    logic       mph_di;
    logic       mph_ei;
    logic [2:0] ei_code;
  } prl1_prim_t;
endpackage

// ---- design/prl1_sync.sv ----
`timescale 1ns/1ns
// ============================================================
// three-stage pin synchroniser, change taken when stages 2, 3 agree
module prl1_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  import prl1_pkg::*;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic [SYNC_STAGES-1:0] sh_r;
      logic                   out_r;
      // first stage feeds only the second
      always_ff @(posedge clock or negedge rstn)
      begin
        if (!rstn)
          sh_r <= '0;
        else
          sh_r <= {sh_r[SYNC_STAGES-2:0], din[i]};
      end
      // agreement filter rejects a single metastable sample
      always_ff @(posedge clock or negedge rstn)
      begin
        if (!rstn)
          out_r <= 1'b0;
        else if (sh_r[1] == sh_r[2])
          out_r <= sh_r[2];
      end
      // one driver per output bit
      assign dout[i] = out_r;
    end
  endgenerate
endmodule

// ---- design/prl1_detect.sv ----
`timescale 1ns/1ns
// ============================================================
// receive condition detector for one side
module prl1_detect #(
  parameter int PCYC = prl1_pkg::PERSIST_CYC
) (
  input  wire logic                clock,
  input  wire logic                rstn,
  input  wire prl1_pkg::prl1_rx_t  rx,
  output prl1_pkg::prl1_det_t      det
);
  import prl1_pkg::*;

  logic        ra_r;
  logic        ez_r;
  logic        ais_r;
  logic        acrc_r;
  logic [9:0]  win_r;
  logic [1:0]  zer_r;
  logic [31:0] per_r;

  // remote alarm: aligned and alarm bit one
  // aligned plus alarm bit
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      ra_r <= 1'b0;
    else if (!rx.frame_aligned)
      ra_r <= 1'b0;
    else if (rx.a_stb)
      ra_r <= rx.a_val;
  end

  // set when the last error-report bit seen was zero
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      ez_r <= 1'b0;
    else if (rx.e_stb)
      ez_r <= !rx.e_val;
  end

  // all-ones window, zero count saturates at the limit
  // window of bit periods
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      win_r <= '0;
      zer_r <= '0;
      ais_r <= 1'b0;
    end
    else if (rx.frame_aligned)
    begin
      win_r <= '0;
      zer_r <= '0;
      ais_r <= 1'b0;
    end
    else if (rx.bit_stb)
    begin
      if (win_r == 10'(AIS_WIN_BITS - 1))
      begin
        win_r <= '0;
        zer_r <= '0;
        // one bit wider so a saturated count plus a last zero cannot wrap
        ais_r <= ({1'b0, zer_r} + 3'(!rx.bit_val)) < 3'(AIS_MIN_ZEROS);
      end
      else
      begin
        win_r <= win_r + 10'h001;
        if (!rx.bit_val && zer_r != 2'(AIS_MIN_ZEROS))
          zer_r <= zer_r + 2'h1;
      end
    end
  end

  // persistence of alarm plus error reports; any break restarts it
  // persistence check
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      per_r  <= '0;
      acrc_r <= 1'b0;
    end
    else if (!(ra_r && ez_r))
    begin
      per_r  <= '0;
      acrc_r <= 1'b0;
    end
    else if (per_r == 32'(PCYC - 1))
      acrc_r <= 1'b1;
    else
      per_r <= per_r + 32'h1;
  end

  assign det.remote_alarm          = ra_r;
  assign det.all_ones_alarm_signal = ais_r;
  assign det.alarm_crc             = acrc_r;
  assign det.lost                  = rx.sig_lost || !rx.frame_aligned;
endmodule

// ---- design/prl1_top.sv ----
`timescale 1ns/1ns
// How it works
// - report status to layer two, management, far side
// - transitions into fault or power off states issue error indication primitives
// - user power off sends nothing
// - user operational sends frames, reports crc errors
// - user fault one keeps frames and reports
// - user fault two sends frames with alarm
// - user fault three sends frames with alarm
// - user fault four sends frames, reports optional
// - user power on left only for a fault state or power off, never straight to operational
// - error reports read per network option
// - continuous reports only under option two
// - network power off sends nothing
// - network operational sends frames, reports errors
// - network fault one sends alarm, gives timing
// - network fault two sends plain frames
// - network fault three sends all ones
// - network fault four sends alarm, reports, timing
// - network power on left after evaluating input
// - remote alarm needs alignment and bit one
// - all-ones needs lost alignment, few zeros
// - alarm with reports needs persistence time
// - errored blocks clear one report bit each in operational, fault one, and user fault four if USER_REPORT_F4
module prl1_top #(
  parameter int  PERSIST_CYCLES = prl1_pkg::PERSIST_CYC,
  parameter bit  USER_REPORT_F4 = 1'b1
) (
  input  wire logic                clock,
  input  wire logic                rstn,
  input  wire logic                user_power_ok,
  input  wire logic                net_power_ok,
  input  wire logic                net_option2,
  input  wire logic                user_act_req,
  input  wire logic                net_act_req,
  input  wire prl1_pkg::prl1_rx_t  user_rx,
  input  wire prl1_pkg::prl1_rx_t  net_rx,
  input  wire logic                net_up_fault,
  input  wire logic                net_up_ais,
  output prl1_pkg::prl1_ust_t      user_state,
  output prl1_pkg::prl1_nst_t      net_state,
  output prl1_pkg::prl1_tx_t       user_tx,
  output prl1_pkg::prl1_tx_t       net_tx,
  output prl1_pkg::prl1_prim_t     user_prim,
  output prl1_pkg::prl1_prim_t     net_prim,
  output logic                     user_e_clear,
  output logic                     net_e_clear
);
  import prl1_pkg::*;

  // ==========================================================
  // pins and detectors
  logic [1:0] pwr_s;
  prl1_det_t  ud;
  prl1_det_t  nd;

  // power sense comes from the supply monitor, not this clock
  prl1_sync #(
    .W (2)
  ) u_sync (
    .clock (clock),
    .rstn  (rstn),
    .din   ({net_power_ok, user_power_ok}),
    .dout  (pwr_s)
  );

  prl1_detect #(
    .PCYC (PERSIST_CYCLES)
  ) u_udet (
    .clock (clock),
    .rstn  (rstn),
    .rx    (user_rx),
    .det   (ud)
  );

  prl1_detect #(
    .PCYC (PERSIST_CYCLES)
  ) u_ndet (
    .clock (clock),
    .rstn  (rstn),
    .rx    (net_rx),
    .det   (nd)
  );

  // ==========================================================
  // user side machine
  prl1_ust_t  us_r;
  prl1_ust_t  us_nxt;
  prl1_ust_t  ut;
  prl1_prim_t up_nxt;

  // target from received conditions, worst first
  always_comb
  begin
    // power on is left only toward a fault state or power off, not operational
    if (ud.lost && ud.all_ones_alarm_signal)
      ut = user_fault_three_state;
    else if (ud.lost)
      ut = user_fault_two_state;
    // continuous reports only with option two
    else if (ud.alarm_crc && net_option2)
      ut = user_fault_four_state;
    else if (ud.remote_alarm)
      ut = user_fault_one_state;
    else
      ut = user_operational_state;
  end

  always_comb
  begin
    us_nxt = us_r;
    up_nxt = '0;
    case (us_r)
      user_power_off_state:
      begin
        if (pwr_s[0])
          us_nxt = user_power_on_state;
      end
      user_operational_state, user_fault_one_state, user_fault_two_state,
      user_fault_three_state, user_fault_four_state, user_power_on_state:
      begin
        if (!pwr_s[0])
        begin
          us_nxt         = user_power_off_state;
          up_nxt.mph_ei  = 1'b1;
          up_nxt.ei_code = EI_POWER_LOSS;
          up_nxt.ph_di   = (us_r == user_operational_state);
          up_nxt.mph_di  = (us_r == user_operational_state);
        end
        else if (ut != us_r && !(ut == user_operational_state
                                  && us_r == user_power_on_state))
        begin
          us_nxt = ut;
          if (ut == user_operational_state)
          begin
            up_nxt.ph_ai  = 1'b1;
            up_nxt.mph_ai = 1'b1;
          end
          else
          begin
            up_nxt.mph_ei  = 1'b1;
            up_nxt.ph_di   = (us_r == user_operational_state);
            up_nxt.mph_di  = (us_r == user_operational_state);
            up_nxt.ei_code = (ut == user_fault_one_state)   ? EI_FAULT_ONE :
                             (ut == user_fault_two_state)   ? EI_FAULT_TWO :
                             (ut == user_fault_three_state) ? EI_FAULT_THR :
                                                              EI_FAULT_FOUR;
          end
        end
        else if (user_act_req)
        begin
          up_nxt.ph_ai  = (us_r == user_operational_state);
          up_nxt.mph_ai = (us_r == user_operational_state);
          up_nxt.ph_di  = (us_r != user_operational_state);
          up_nxt.mph_di = (us_r != user_operational_state);
        end
      end
      default:
        us_nxt = user_power_off_state;
    endcase
  end

  // user transmit content per state
  function automatic prl1_tx_t utx(input prl1_ust_t s);
    prl1_tx_t t;
    t = '0;
    case (s)
      user_operational_state, user_fault_one_state, user_fault_four_state:
      begin
        t.send     = 1'b1;
        t.crc_bits = 1'b1;
        t.timing   = 1'b1;
      end
      user_fault_two_state, user_fault_three_state:
      begin
        t.send         = 1'b1;
        t.crc_bits     = 1'b1;
        t.remote_alarm = 1'b1;
      end
      // power off and power on send nothing
      default:
        t = '0;
    endcase
    return t;
  endfunction

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      us_r <= user_power_off_state;
    else
      us_r <= us_nxt;
  end

  // status and primitives toward higher layers
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      user_tx   <= '0;
      user_prim <= '0;
    end
    else
    begin
      user_tx   <= utx(us_nxt);
      user_prim <= up_nxt;
    end
  end

  // one cleared report bit per errored block in operational, fault one, and fault four if USER_REPORT_F4
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      user_e_clear <= 1'b0;
    else
      user_e_clear <= user_rx.crc_err && (us_r == user_operational_state
                      || us_r == user_fault_one_state
                      || (us_r == user_fault_four_state && USER_REPORT_F4));
  end

  // ==========================================================
  // network side machine
  prl1_nst_t  ns_r;
  prl1_nst_t  ns_nxt;
  prl1_nst_t  nt;
  prl1_prim_t np_nxt;

  // power on left once input evaluated
  always_comb
  begin
    if (nd.lost)
      nt = network_fault_four_state;
    else if (nd.remote_alarm && net_up_ais)
      nt = network_fault_three_state;
    else if (nd.remote_alarm)
      nt = network_fault_two_state;
    else if (net_up_fault)
      nt = network_fault_one_state;
    else
      nt = network_operational_state;
  end

  always_comb
  begin
    ns_nxt = ns_r;
    np_nxt = '0;
    case (ns_r)
      network_power_off_state:
      begin
        if (pwr_s[1])
          ns_nxt = network_power_on_state;
      end
      network_operational_state, network_fault_one_state,
      network_fault_two_state, network_fault_three_state,
      network_fault_four_state, network_power_on_state:
      begin
        if (!pwr_s[1])
        begin
          ns_nxt         = network_power_off_state;
          np_nxt.mph_ei  = 1'b1;
          np_nxt.ei_code = EI_POWER_LOSS;
          np_nxt.ph_di   = (ns_r == network_operational_state);
          np_nxt.mph_di  = (ns_r == network_operational_state);
        end
        else if (nt != ns_r)
        begin
          ns_nxt = nt;
          if (nt == network_operational_state)
          begin
            np_nxt.ph_ai  = 1'b1;
            np_nxt.mph_ai = 1'b1;
          end
          else
          begin
            np_nxt.mph_ei  = 1'b1;
            np_nxt.ph_di   = (ns_r == network_operational_state);
            np_nxt.mph_di  = (ns_r == network_operational_state);
            np_nxt.ei_code = (nt == network_fault_one_state) ? EI_FAULT_ONE :
                             (nt == network_fault_two_state) ? EI_FAULT_TWO :
                             (nt == network_fault_three_state) ? EI_FAULT_THR :
                                                                 EI_FAULT_FOUR;
          end
        end
        else if (net_act_req)
        begin
          np_nxt.ph_ai  = (ns_r == network_operational_state);
          np_nxt.mph_ai = (ns_r == network_operational_state);
          np_nxt.ph_di  = (ns_r != network_operational_state);
          np_nxt.mph_di = (ns_r != network_operational_state);
        end
      end
      default:
        ns_nxt = network_power_off_state;
    endcase
  end

  function automatic prl1_tx_t ntx(input prl1_nst_t s, input logic opt2);
    prl1_tx_t t;
    t = '0;
    case (s)
      network_operational_state:
      begin
        t.send     = 1'b1;
        t.crc_bits = 1'b1;
        t.timing   = 1'b1;
      end
      network_fault_one_state:
      begin
        t.send         = 1'b1;
        t.crc_bits     = 1'b1;
        t.remote_alarm = 1'b1;
        t.timing       = 1'b1;
      end
      network_fault_two_state:
      begin
        t.send     = 1'b1;
        t.crc_bits = 1'b1;
      end
      network_fault_three_state:
      begin
        t.send     = 1'b1;
        t.all_ones = 1'b1;
      end
      // alarm plus continuous reports under option two, timing kept
      network_fault_four_state:
      begin
        t.send            = 1'b1;
        t.crc_bits        = 1'b1;
        t.remote_alarm    = 1'b1;
        t.cont_crc_report = opt2;
        t.timing          = 1'b1;
      end
      // power off and power on send nothing
      default:
        t = '0;
    endcase
    return t;
  endfunction

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      ns_r <= network_power_off_state;
    else
      ns_r <= ns_nxt;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      net_tx   <= '0;
      net_prim <= '0;
    end
    else
    begin
      net_tx   <= ntx(ns_nxt, net_option2);
      net_prim <= np_nxt;
    end
  end

  // reports only where frames carry them normally
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      net_e_clear <= 1'b0;
    else
      net_e_clear <= net_rx.crc_err && (ns_r == network_operational_state
                     || ns_r == network_fault_one_state);
  end

  assign user_state = us_r;
  assign net_state  = ns_r;
endmodule

// ---- sim/prl1_far.sv ----
`timescale 1ns/1ns
// ==========================================================
// far-side line model: receive status seen by one side
// mode 0 none, 1 normal, 2 alarm, 3 lost, 4 all ones, 5 alarm with reports
module prl1_far (
  input  wire logic         clock,
  input  wire logic [2:0]   mode,
  input  wire logic         crc_inj,
  output prl1_pkg::prl1_rx_t rx
);
  import prl1_pkg::*;
  logic [1:0] ph_r  = 2'h0;
  logic       tog_r = 1'b0;
  // phase places alarm and report bits in separate slots
  always_ff @(negedge clock)
  begin
    ph_r  <= ph_r + 2'h1;
    tog_r <= ~tog_r;
  end
  // line content of the commanded condition
  always_comb
  begin
    rx.frame_aligned = mode inside {3'h1, 3'h2, 3'h5};
    rx.sig_lost      = mode inside {3'h0, 3'h3};
    rx.bit_stb       = !rx.sig_lost;
    rx.bit_val       = (mode == 3'h4) ? 1'b1 : tog_r; // other modes alternate ones and zeros
    rx.a_stb         = rx.frame_aligned && ph_r == 2'h0;
    rx.a_val         = mode inside {3'h2, 3'h5};
    rx.e_stb         = rx.frame_aligned && ph_r == 2'h2;
    rx.e_val         = mode != 3'h5;
    rx.crc_err       = crc_inj;
  end
endmodule

// ---- sim/prl1_chk.sv ----
`timescale 1ns/1ns
// ==========================================================
// port checker for both state machines
module prl1_chk #(
  parameter int PERSIST_CYCLES = 20
) (
  input wire logic                 clock,
  input wire logic                 rstn,
  input wire logic                 user_power_ok,
  input wire logic                 net_option2,
  input wire prl1_pkg::prl1_rx_t   user_rx,
  input wire prl1_pkg::prl1_ust_t  user_state,
  input wire prl1_pkg::prl1_nst_t  net_state,
  input wire prl1_pkg::prl1_tx_t   user_tx,
  input wire prl1_pkg::prl1_tx_t   net_tx,
  input wire prl1_pkg::prl1_prim_t user_prim,
  input wire logic                 user_e_clear
);
  import prl1_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // entries into a state, seen against the previous edge
  sequence s_enter_uf2;
    user_state == user_fault_two_state && $past(user_state) != user_fault_two_state;
  endsequence
  sequence s_enter_uoff;
    user_state == user_power_off_state && $past(user_state) != user_power_off_state;
  endsequence
  a_uoff_quiet: assert property (user_state == user_power_off_state |-> !user_tx.send)
    else $error("user sends while powered off");
  a_noff_quiet: assert property (net_state == network_power_off_state |-> !net_tx.send)
    else $error("network sends while powered off");
  a_uf2_alarm: assert property (user_state == user_fault_two_state
    |-> user_tx.send && user_tx.crc_bits && user_tx.remote_alarm)
    else $error("user fault two content wrong");
  a_uf3_alarm: assert property (user_state == user_fault_three_state
    |-> user_tx.send && user_tx.crc_bits && user_tx.remote_alarm)
    else $error("user fault three content wrong");
  a_nf1_timing: assert property (net_state == network_fault_one_state
    |-> net_tx.remote_alarm && net_tx.timing && !net_tx.all_ones)
    else $error("network fault one content wrong");
  a_nf2_plain: assert property (net_state == network_fault_two_state
    |-> net_tx.send && !net_tx.remote_alarm && !net_tx.timing)
    else $error("network fault two content wrong");
  a_nf3_ones: assert property (net_state == network_fault_three_state |-> net_tx.all_ones)
    else $error("network fault three lacks all ones");
  a_nf4_report: assert property (net_state == network_fault_four_state
    |-> net_tx.remote_alarm && net_tx.timing && net_tx.cont_crc_report == net_option2)
    else $error("network fault four content wrong");
  a_uop_eclear: assert property (user_state == user_operational_state && user_rx.crc_err
    |=> user_e_clear)
    else $error("errored block not reported");
  a_uf2_prim: assert property (s_enter_uf2
    |-> user_prim.mph_ei && user_prim.ei_code == EI_FAULT_TWO)
    else $error("fault two entry without indication");
  a_uoff_prim: assert property (s_enter_uoff
    |-> user_prim.mph_ei && user_prim.ei_code == EI_POWER_LOSS)
    else $error("power loss without indication");
  a_upwr_on: assert property ($rose(user_power_ok) && user_state == user_power_off_state
    |-> ##[1:8] user_state == user_power_on_state)
    else $error("power return not seen");
endmodule

bind prl1_top prl1_chk #(.PERSIST_CYCLES(PERSIST_CYCLES)) i_chk (.clock, .rstn,
  .user_power_ok, .net_option2, .user_rx, .user_state, .net_state, .user_tx, .net_tx,
  .user_prim, .user_e_clear);

// ---- sim/prl1_top_bench.sv ----
`timescale 1ns/1ns
module prl1_top_bench;
  import prl1_pkg::*;
  logic       clock = 1'b0;
  logic       rstn, upok, npok, uact, nact, ucrc, ncrc, nflt, nais, ue, ne, opt2;
  logic [2:0] umode, nmode, uc;
  prl1_rx_t   urx, nrx;
  prl1_ust_t  ust;
  prl1_nst_t  nst;
  prl1_tx_t   utx, ntx;
  prl1_prim_t upr, npr, su, sn;
  logic       uecl, necl;
  wire  [6:0] us7 = ust;
  wire  [6:0] ns7 = nst;
  int         fails = 0;
  int         compares = 0;
  // ==========================================================
  // clock and instances
  always #20 clock = ~clock;
  prl1_far i_ufar (.clock(clock), .mode(umode), .crc_inj(ucrc), .rx(urx));
  prl1_far i_nfar (.clock(clock), .mode(nmode), .crc_inj(ncrc), .rx(nrx));
  prl1_top #(.PERSIST_CYCLES(20)) i_dut (.clock(clock), .rstn(rstn), .user_power_ok(upok),
    .net_power_ok(npok), .net_option2(opt2), .user_act_req(uact), .net_act_req(nact),
    .user_rx(urx), .net_rx(nrx), .net_up_fault(nflt), .net_up_ais(nais), .user_state(ust),
    .net_state(nst), .user_tx(utx), .net_tx(ntx), .user_prim(upr), .net_prim(npr),
    .user_e_clear(uecl), .net_e_clear(necl));
  // one-cycle pulses are gathered just after each edge, cleared by tasks
  always @(posedge clock)
  begin
    #2;
    su = su | upr;
    sn = sn | npr;
    ue = ue | uecl;
    ne = ne | necl;
    if (upr.mph_ei === 1'b1) uc = upr.ei_code;
  end
  // ==========================================================
  // shared tasks
  task close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task clr();
    su = '0;
    sn = '0;
    ue = 1'b0;
    ne = 1'b0;
  endtask
  // bounded wait for a state; a spent bound ends the run
  task wait_st(input bit net, input logic [6:0] s);
    int n;
    n = 0;
    while ((net ? ns7 : us7) !== s && n < 1200)
    begin
      @(negedge clock);
      n++;
    end
    chk({1'b0, net ? ns7 : us7}, {1'b0, s});
    if (n == 1200) close_out();
    cyc(1);
  endtask
  task automatic pulse(ref logic sig);
    sig = 1'b1;
    cyc(1);
    sig = 1'b0;
    cyc(2);
  endtask
  // ==========================================================
  // scenarios
  task t_power_up();
    upok = 1'b1;
    npok = 1'b1;
    umode = 3'h1;
    nmode = 3'h1;
    wait_st(1, network_operational_state);
    chk(ntx.send && ntx.crc_bits && !ntx.remote_alarm, 1);
    wait_st(0, user_power_on_state);
    cyc(10);
    chk(us7, user_power_on_state);
    chk(utx.send, 0);
  endtask
  task t_user_faults();
    clr();
    umode = 3'h3;
    wait_st(0, user_fault_two_state);
    chk(uc, EI_FAULT_TWO);
    clr();
    umode = 3'h1;
    wait_st(0, user_operational_state);
    chk(su.ph_ai && su.mph_ai, 1);
    pulse(ucrc);
    chk(ue, 1);
    clr();
    umode = 3'h2;
    wait_st(0, user_fault_one_state);
    chk({su.ph_di, uc}, {1'b1, EI_FAULT_ONE});
    pulse(ucrc);
    chk(ue && utx.send && !utx.remote_alarm, 1);
    umode = 3'h5;
    cyc(10);
    chk(us7, user_fault_one_state);
    wait_st(0, user_fault_four_state);
    chk({utx.send, utx.crc_bits, uc}, {2'h3, EI_FAULT_FOUR});
    clr();
    pulse(ucrc);
    chk(ue, 1);
    umode = 3'h4;
    wait_st(0, user_fault_three_state);
    chk({utx.remote_alarm, uc}, {1'b1, EI_FAULT_THR});
    clr();
    pulse(uact);
    chk(su.ph_di && !su.ph_ai, 1);
    umode = 3'h1;
    wait_st(0, user_operational_state);
    clr();
    pulse(uact);
    chk(su.ph_ai && su.mph_ai, 1);
  endtask
  task t_net_faults();
    nflt = 1'b1;
    wait_st(1, network_fault_one_state);
    chk(ntx.remote_alarm && ntx.timing, 1);
    nflt = 1'b0;
    nmode = 3'h2;
    wait_st(1, network_fault_two_state);
    chk({ntx.send, ntx.remote_alarm, ntx.timing}, 3'h4);
    nais = 1'b1;
    wait_st(1, network_fault_three_state);
    chk(ntx.all_ones, 1);
    nais = 1'b0;
    nmode = 3'h3;
    wait_st(1, network_fault_four_state);
    chk({ntx.remote_alarm, ntx.cont_crc_report, ntx.timing}, 3'h7);
    nmode = 3'h1;
    wait_st(1, network_operational_state);
    clr();
    pulse(ncrc);
    chk(ne, 1);
    pulse(nact);
    chk(sn.ph_ai, 1);
  endtask
  // option one: alarm with reports stays fault one, no continuous reports
  task t_option_one();
    opt2 = 1'b0;
    umode = 3'h5;
    wait_st(0, user_fault_one_state);
    cyc(40);
    chk(us7, user_fault_one_state);
    nmode = 3'h3;
    wait_st(1, network_fault_four_state);
    chk({ntx.remote_alarm, ntx.cont_crc_report, ntx.timing}, 3'h5);
  endtask
  task t_power_off();
    clr();
    upok = 1'b0;
    npok = 1'b0;
    wait_st(0, user_power_off_state);
    chk({utx.send, uc}, {1'b0, EI_POWER_LOSS});
    wait_st(1, network_power_off_state);
    chk(ntx.send, 0);
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    {rstn, upok, npok, uact, nact, ucrc, ncrc, nflt, nais} = '0;
    opt2 = 1'b1;
    umode = 3'h0;
    nmode = 3'h0;
    uc = 3'h7;
    clr();
    cyc(4);
    chk({us7, ntx.send}, {user_power_off_state, 1'b0});
    rstn = 1'b1;
    cyc(2);
    t_power_up();
    t_user_faults();
    t_net_faults();
    t_option_one();
    t_power_off();
    close_out();
  end
endmodule
